// *** test/cmp_mem_model.sv ***
/*
  Behavioural external memory answering the memory port one word at a time.
  Assumes the port holds mem_request high while words are outstanding.
*/
`timescale 1ns/1ns
module cmp_mem_model (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       mem_request,
  input  wire logic       stall,
  input  wire logic       abort_en,
  input  wire logic [1:0] abort_word,
  input  wire logic [1:0] wait_cyc,
  output logic            word_done,
  output logic            ext_abort
);
  // ==========================================================
  // Word timing
  logic [1:0] cnt;
  logic [1:0] idx;
  always_ff @(posedge clk_sys) begin
    word_done <= 1'b0;
    ext_abort <= 1'b0;
    // Only a real request is served; a bare address is ignored
    if (rst || !mem_request) begin
      cnt <= 2'h0;
      idx <= 2'h0;
    end else if (!stall) begin
      if (word_done) begin
        cnt <= 2'h0;
      end else if (cnt < wait_cyc) begin
        cnt <= cnt + 2'h1;
      end else begin
        word_done <= 1'b1;
        ext_abort <= abort_en && (idx == abort_word);
        idx       <= idx + 2'h1;
      end
    end
  end
endmodule : cmp_mem_model

// *** test/testbench.sv ***
/*
  Self-checking bench for the memory port with a memory model.
  Assumes the design package and both modules are compiled first.
*/
`timescale 1ns/1ns
module testbench;
  import cmp_pkg::*;
  logic clk_sys, rst, fast_clock_strap, req_valid, req_write, req_byte;
  logic req_linefetch, req_int_abort, req_page_updateable, word_done;
  logic ext_abort, req_ready, mem_request, fast_mode, addr_latch_bypass;
  logic abort_to_core, line_fill_valid, line_purge, cache_update;
  logic stall, abort_en;
  logic [1:0] req_words, abort_word, wait_cyc;
  logic [31:0] req_addr, mem_addr;
  logic [3:0] byte_lane_select_n, fault_status_code, wb_data_count;
  logic [2:0] wb_addr_count;
  logic [1:0] fq[$];
  logic aq[$], wq[$];
  int err_total, n_compared, j;
  int seed = 32'h5b6ff4a3;
  cmp_port u_cmp_port (.*);
  cmp_mem_model u_cmp_mem_model (.*);
  // ==========================================================
  // Checking
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task complete_run;
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  always @(negedge clk_sys) if (!rst) begin
    if (line_fill_valid | line_purge)
      chk("line", fq.size() ? fq.pop_front() : 2'h0,
          {line_fill_valid, line_purge});
    if (abort_to_core) chk("abort", aq.size() ? aq.pop_front() : 1'b0, 1);
    if (cache_update) chk("update", wq.size() ? wq.pop_front() : 1'b0, 1);
  end
  // ==========================================================
  // Stimulus
  task automatic req(input logic w, b, l, i, r, input logic [1:0] n);
    int k;
    logic [3:0] e;
    @(posedge clk_sys);
    #2 {req_write, req_byte, req_linefetch, req_int_abort} = {w, b, l, i};
    req_words = n;
    req_addr = $random(seed);
    req_page_updateable = 1'($random(seed));
    req_valid = 1'b1;
    e = b ? ~(4'h1 << req_addr[1:0]) : 4'h0;
    #1 chk("lanes", e, byte_lane_select_n);
    if (r) chk("ready", 0, req_ready);
    else for (k = 0; k < 200 && req_ready !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (!r) chk("ready", 1, req_ready);
    @(posedge clk_sys);
    #2 req_valid = 1'b0;
  endtask : req
  task automatic idle;
    int k;
    for (k = 0; k < 300 && mem_request !== 1'b0; k++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : idle
  task reset_with(input logic s);
    @(posedge clk_sys);
    #2 rst = 1'b1;
    fast_clock_strap = s;
    repeat (3) @(posedge clk_sys);
    #2 rst = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("fast", s, fast_mode);
    chk("latch", s, addr_latch_bypass);
  endtask : reset_with
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    #(3000 * 50);
    err_total++;
    complete_run();
  end
  initial begin
    rst = 1'b1;
    {req_valid, req_write, req_byte, req_linefetch, req_int_abort} = 0;
    {req_page_updateable, req_words, req_addr, stall, abort_en} = 0;
    {abort_word, wait_cyc, err_total, n_compared} = 0;
    reset_with(1'b0);
    for (j = 0; j < 5; j++) begin
      abort_en = j < 4;
      abort_word = 2'(j);
      wait_cyc = 2'($random(seed));
      if (j < 4) aq.push_back(1'b1);
      fq.push_back(j < 4 ? 2'h1 : 2'h2);
      req(0, 0, 1, 0, 0, 0);
      idle();
      if (j < 4) chk("code", CMP_FSR_EXT_LINE, fault_status_code);
    end
    abort_en = 1'b1;
    abort_word = 2'h0;
    aq.push_back(1'b1);
    fq.push_back(2'h1);
    req(0, 1, 0, 0, 0, 0);
    idle();
    chk("code", CMP_FSR_EXT_WORD, fault_status_code);
    fq.push_back(2'h1);
    req(0, 0, 0, 1, 0, 0);
    repeat (6) begin
      @(posedge clk_sys);
      #1 chk("memreq", 0, mem_request);
    end
    stall = 1;
    repeat (4) begin
      wq.push_back(1'b1);
      req(1, 1, 0, 0, 0, 0);
    end
    chk("addrs", CMP_WB_ADDRS, wb_addr_count);
    req(1, 1, 0, 0, 1, 0);
    stall = 0;
    idle();
    chk("addrs", 0, wb_addr_count);
    stall = 1;
    repeat (2) begin
      wq.push_back(1'b1);
      req(1, 0, 0, 0, 0, 2'h3);
    end
    chk("data", CMP_WB_DATA, wb_data_count);
    req(1, 0, 0, 0, 1, 0);
    stall = 0;
    idle();
    chk("data", 0, wb_data_count);
    chk("left", 0, fq.size() + aq.size() + wq.size());
    reset_with(1'b1);
    complete_run();
  end
endmodule : testbench

// *** verilog/cmp_lane_decode.sv ***
/*
  Active-low byte lane decode from the two low address bits.
  Assumes a valid flag qualifies the access.
*/
`timescale 1ns/1ns
module cmp_lane_decode
  import cmp_pkg::*;
(
  input  wire logic       valid,
  input  wire logic       byte_access,
  input  wire logic [1:0] addr_low,
  output wire logic [3:0] lanes_n
);
  wire logic [3:0] byte_lanes_n;
  genvar i;
  // ==========================================================
  // Decode
  generate
    for (i = 0; i < 4; i++) begin : g_lane
      assign byte_lanes_n[i] = (addr_low != 2'(i)); // R14
    end
  endgenerate
  assign lanes_n = !valid ? CMP_LANES_NONE :
                   byte_access ? byte_lanes_n : CMP_LANES_ALL; // R10
endmodule : cmp_lane_decode

// *** verilog/cmp_pkg.sv ***
/*
  Constants and types for the cached processor memory port block:
  strap, byte lanes, abort handling, write buffer and cache geometry.
  Assumes a single 20 MHz system clock and synchronous active-high reset.
*/
// Overview of operation
// R1: Strap selects clocking; ground means legacy mode
// R2: Only late abort timing is supported
// R3: Abort on any line word keeps cache clean
// R4: Internal abort may show address, no access
// R5: Memory ignores spurious address of internal abort
// R6: Abort ignored during buffered writes
// R7: Fault code 00x0 never produced
// R8: Write buffer holds four addresses
// R9: Write buffer data queue has eight entries
// R10: Byte lanes are active-low decode of address
// R11: Cache is 8kB, four-way set associative
// R12: Internal abort may invalidate affected lines
// R13: Updateable page flag ignored; writes update cache
// R14: Byte access lowers lane matching address bits
package cmp_pkg;
  // ==========================================================
  // Cache geometry
  localparam int CMP_CACHE_BYTES = 8192;
  localparam int CMP_CACHE_WAYS  = 4;
  localparam int CMP_LINE_WORDS  = 4;
  localparam int CMP_SETS        = CMP_CACHE_BYTES / (CMP_CACHE_WAYS * 4 *
                                   CMP_LINE_WORDS);
  // ==========================================================
  // Write buffer depths
  localparam int CMP_WB_ADDRS = 4;
  localparam int CMP_WB_DATA  = 8;
  // ==========================================================
  // Fault status codes
  localparam logic [3:0] CMP_FSR_NONE     = 4'h0;
  localparam logic [3:0] CMP_FSR_EXT_LINE = 4'h4;
  localparam logic [3:0] CMP_FSR_EXT_WORD = 4'h8;
  localparam logic [3:0] CMP_FSR_BANNED   = 4'h0;
  // ==========================================================
  // Byte lane values with no valid request and for word accesses
  localparam logic [3:0] CMP_LANES_ALL  = 4'h0;
  localparam logic [3:0] CMP_LANES_NONE = 4'hf;
  typedef enum logic [1:0] {CMP_IDLE, CMP_FETCH, CMP_BWRITE} cmp_state_t;
endpackage : cmp_pkg

// *** verilog/cmp_port.sv ***
/*
  Memory port of the cached processor: strap capture, byte lanes,
  late abort handling, write buffer occupancy and cache line validity.
  Assumes the core presents one request at a time with a valid strobe and
  the memory side returns a one-cycle done pulse per word.
*/
`timescale 1ns/1ns
module cmp_port
  import cmp_pkg::*;
#(
  parameter int WB_ADDRS = CMP_WB_ADDRS,
  parameter int WB_DATA  = CMP_WB_DATA
)(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        fast_clock_strap,
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic        req_byte,
  input  wire logic        req_linefetch,
  input  wire logic        req_int_abort,
  input  wire logic        req_page_updateable,
  input  wire logic [31:0] req_addr,
  input  wire logic [1:0]  req_words,
  output wire logic        req_ready,
  input  wire logic        word_done,
  input  wire logic        ext_abort,
  output wire logic [3:0]  byte_lane_select_n,
  output logic      [31:0] mem_addr,
  output wire logic        mem_request,
  output logic             fast_mode,
  output logic             addr_latch_bypass,
  output logic             abort_to_core,
  output logic      [3:0]  fault_status_code,
  output logic             line_fill_valid,
  output logic             line_purge,
  output logic             cache_update,
  output logic      [2:0]  wb_addr_count,
  output logic      [3:0]  wb_data_count
);
  cmp_state_t state;
  cmp_state_t next_state;
  logic        strap_taken;
  logic        fetch_abort;
  logic [1:0]  fetch_left;
  // Entry pointers wrap cleanly only for a power-of-two depth
  localparam int PTR_W = $clog2(WB_ADDRS);
  logic        in_write;
  logic        req_linefetch_q;
  logic [3:0]  next_fsr;
  logic [3:0]  head_done;
  logic [PTR_W-1:0] wb_wr;
  logic [PTR_W-1:0] wb_rd;
  logic [3:0]  wb_len [WB_ADDRS];
  wire  logic  wb_push;
  wire  logic  head_last;
  wire  logic  accept;
  wire  logic  wb_room;
  wire  logic  drain;
  wire  logic  fetch_last;
  wire  logic  abort_now;
  wire  logic [3:0] word_cnt;

  // ==========================================================
  // Strap capture after reset release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strap_taken       <= 1'b0;
      fast_mode         <= 1'b0;
      addr_latch_bypass <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken       <= 1'b1;
      fast_mode         <= fast_clock_strap; // R1
      addr_latch_bypass <= fast_clock_strap; // R1
    end
  end

  // ==========================================================
  // Request acceptance and bus request
  assign word_cnt = req_byte ? 4'h1 : {2'b00, req_words} + 4'h1;
  assign wb_room  = (wb_addr_count < 3'(WB_ADDRS)) &&
                    ({1'b0, wb_data_count} + {1'b0, word_cnt} <=
                     5'(WB_DATA)); // R8 R9
  // Reads wait for an empty buffer; writes queue behind the drain
  assign req_ready = strap_taken &&
                     (req_write ? (state != CMP_FETCH) && wb_room
                                : (state == CMP_IDLE));
  assign wb_push   = accept && req_write && !req_int_abort;
  assign accept = req_valid && req_ready;
  // Internally aborted accesses reach no memory
  assign mem_request = (state == CMP_FETCH) ||
                       (state == CMP_BWRITE) ||
                       (accept && !req_int_abort); // R4
  assign drain = (state == CMP_BWRITE) && word_done;
  // Head address leaves once all of its words have drained
  assign head_last = drain && (head_done + 4'h1 == wb_len[wb_rd]);
  assign fetch_last = (state == CMP_FETCH) && word_done &&
                      (fetch_left == 2'h0);
  // Late abort: sampled with the word that ends, never during writes
  assign abort_now = ext_abort && word_done &&
                     (state == CMP_FETCH) && !in_write; // R2 R6

  cmp_lane_decode u_lanes (
    .valid       (req_valid),
    .byte_access (req_byte),
    .addr_low    (req_addr[1:0]),
    .lanes_n     (byte_lane_select_n)
  );

  // ==========================================================
  // State machine
  always_comb begin
    next_state = state;
    case (state)
      CMP_IDLE: begin
        if (accept && !req_int_abort)
          next_state = req_write ? CMP_BWRITE : CMP_FETCH;
      end
      CMP_FETCH:  if (fetch_last) next_state = CMP_IDLE;
      CMP_BWRITE: if (head_last && wb_addr_count == 3'h1 && !wb_push)
                    next_state = CMP_IDLE;
      default:    next_state = CMP_IDLE;
    endcase
  end

  always_comb begin
    next_fsr = fault_status_code;
    if (abort_now)
      next_fsr = (fetch_abort || fetch_left != 2'h0 || req_linefetch_q) ?
                 CMP_FSR_EXT_LINE : CMP_FSR_EXT_WORD; // R7
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state           <= CMP_IDLE;
      mem_addr        <= 32'h0000_0000;
      fetch_left      <= 2'h0;
      fetch_abort     <= 1'b0;
      in_write        <= 1'b0;
      req_linefetch_q <= 1'b0;
    end else begin
      state <= next_state;
      if (accept && !req_int_abort) begin
        mem_addr        <= req_addr; // R4
        in_write        <= req_write;
        req_linefetch_q <= req_linefetch;
        fetch_left      <= req_linefetch ? 2'(CMP_LINE_WORDS - 1) : 2'h0;
        fetch_abort     <= 1'b0;
      end else if (state == CMP_FETCH && word_done) begin
        fetch_left  <= fetch_left - 2'h1;
        fetch_abort <= fetch_abort | abort_now; // R3
      end
    end
  end

  // ==========================================================
  // Core abort and fault status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      abort_to_core     <= 1'b0;
      fault_status_code <= CMP_FSR_NONE;
    end else begin
      abort_to_core     <= abort_now; // R6
      fault_status_code <= next_fsr;
    end
  end

  // ==========================================================
  // Cache line validity
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      line_fill_valid <= 1'b0;
      line_purge      <= 1'b0;
      cache_update    <= 1'b0;
    end else begin
      // Line marked valid only when no word of it aborted
      line_fill_valid <= fetch_last && !fetch_abort && !abort_now; // R3
      line_purge      <= (accept && req_int_abort) ||
                         (fetch_last && (fetch_abort || abort_now)); // R12
      // Page flag deliberately ignored
      cache_update    <= accept && req_write && !req_int_abort; // R13
    end
  end

  // ==========================================================
  // Write buffer occupancy
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_addr_count <= 3'h0;
      wb_data_count <= 4'h0;
      wb_wr         <= PTR_W'(0);
      wb_rd         <= PTR_W'(0);
      head_done     <= 4'h0;
    end else begin
      wb_addr_count <= wb_addr_count + 3'(wb_push) - 3'(head_last); // R8
      wb_data_count <= wb_data_count + (wb_push ? word_cnt : 4'h0) -
                       4'(drain); // R9
      if (wb_push) wb_wr <= wb_wr + PTR_W'(1);
      if (head_last) wb_rd <= wb_rd + PTR_W'(1);
      if (drain) head_done <= head_last ? 4'h0 : head_done + 4'h1;
    end
  end

  // Word count of each queued address
  generate
    for (genvar e = 0; e < WB_ADDRS; e++) begin : g_wb_len
      always_ff @(posedge clk_sys) begin
        if (rst)
          wb_len[e] <= 4'h0;
        else if (wb_push && wb_wr == PTR_W'(e))
          wb_len[e] <= word_cnt; // R9
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  sequence s_last_word;
    fetch_last;
  endsequence
  strap_legacy_a: assert property ( // R1
    @(posedge clk_sys) disable iff (rst)
    strap_taken && !$past(fast_clock_strap) && !$past(strap_taken) |->
    !fast_mode) else $error("strap low not legacy mode");
  late_abort_a: assert property ( // R2
    @(posedge clk_sys) disable iff (rst)
    abort_to_core |-> $past(ext_abort) && $past(word_done))
    else $error("abort without late sample");
  clean_fill_a: assert property ( // R3
    @(posedge clk_sys) disable iff (rst)
    s_last_word ##0 (fetch_abort || abort_now) |=> !line_fill_valid)
    else $error("aborted line filled");
  no_spurious_a: assert property ( // R4
    @(posedge clk_sys) disable iff (rst)
    state == CMP_IDLE && req_int_abort |-> !mem_request)
    else $error("internal abort reached memory");
  write_abort_a: assert property ( // R6
    @(posedge clk_sys) disable iff (rst)
    state == CMP_BWRITE && ext_abort |=> !abort_to_core)
    else $error("abort on buffered write");
  fsr_code_a: assert property ( // R7
    @(posedge clk_sys) disable iff (rst)
    abort_to_core |-> (fault_status_code & 4'hd) != CMP_FSR_BANNED)
    else $error("banned fault code");
  wb_addr_a: assert property ( // R8
    @(posedge clk_sys) disable iff (rst)
    wb_addr_count <= 3'(WB_ADDRS)) else $error("address queue overrun");
  wb_data_a: assert property ( // R9
    @(posedge clk_sys) disable iff (rst)
    wb_data_count <= 4'(WB_DATA)) else $error("data queue overrun");
  lane_word_a: assert property ( // R10
    @(posedge clk_sys) disable iff (rst)
    req_valid && !req_byte |-> byte_lane_select_n == CMP_LANES_ALL)
    else $error("word lanes not all low");
  lane_byte_a: assert property ( // R14
    @(posedge clk_sys) disable iff (rst)
    req_valid && req_byte |-> !byte_lane_select_n[req_addr[1:0]] &&
    $onehot(~byte_lane_select_n)) else $error("byte lane wrong");
  purge_a: assert property ( // R12
    @(posedge clk_sys) disable iff (rst)
    accept && req_int_abort |=> line_purge)
    else $error("no purge on internal abort");
  update_a: assert property ( // R13
    @(posedge clk_sys) disable iff (rst)
    accept && req_write && !req_int_abort && !req_page_updateable |=>
    cache_update) else $error("write skipped cache update");
  geom_a: assert property ( // R11
    @(posedge clk_sys) disable iff (rst)
    CMP_SETS * CMP_CACHE_WAYS * CMP_LINE_WORDS * 4 == CMP_CACHE_BYTES)
    else $error("cache geometry wrong");
endmodule : cmp_port
